// ==== hdl/obcl_loader.sv ====
// Option byte configuration loader with AHB-Lite status access
// What this block does
// - Load five option bytes after every reset
// - Boot swap fetches from the alternate area
// - Start option picks reset release voltage level
// - Start option writable only by external programmer
// - Third byte picks high-speed oscillator frequency
// - Fourth byte picks debug pin pair
// - Fifth byte gives four debug states
// - Debug bits: off, forbidden, no-erase, erase
// - Byte0 bits 6:5 set watchdog window
// - Byte0 bit4 starts watchdog and access detection
// - Byte0 bits 3:1 set watchdog overflow time
// - Byte0 bit0 locks low-speed oscillator running
// - Watchdog keeps counting during self-programming
// - Unlocked oscillator gates watchdog in HALT/STOP
// - Eight-bit timer keeps clock in HALT/STOP
// - Low-power mode rewrites data area only
// - Low-power written flash unreadable in normal mode
`timescale 1ns/100ps
module obcl_loader (
  input  wire logic                      clk,
  input  wire logic                      rst,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic      [31:0]               hrdata,
  // Flash option byte read port
  output logic                           flash_req,
  output logic      [15:0]               flash_addr,
  input  wire logic                      flash_ack,
  input  wire logic [7:0]                flash_rdata,
  // Mode inputs from logic on this clock
  input  wire logic                      boot_swap,
  input  wire logic                      self_prog,
  input  wire logic                      ext_programmer,
  input  wire logic                      rmc_low_power,
  input  wire logic                      halt_mode,
  input  wire logic                      stop_mode,
  input  wire logic                      lowspeed_osc_stop_req,
  // Analog supply comparators, asynchronous
  input  wire logic                      supply_above_hi,
  input  wire logic                      supply_above_lo,
  // Flash rewrite and read checks
  input  obcl_pkg::obcl_flash_req_t      fw_req,
  input  wire logic                      fr_req,
  output logic                           fw_grant,
  output logic                           fw_refuse,
  output logic                           fr_block,
  // Configuration outputs
  output logic                           cpu_reset_hold,
  output logic                           cfg_done,
  output logic      [1:0]                wdt_window_sel,
  output logic                           wdt_autostart,
  output logic                           wdt_access_det_en,
  output logic      [4:0]                wdt_overflow_exp,
  output logic                           wdt_clk_en,
  output logic                           lowspeed_osc_lock,
  output logic                           lowspeed_osc_run,
  output logic                           aux_8bit_timer_clk_en,
  output logic                           lvd_default_start,
  output logic                           hs_osc_4mhz,
  output logic                           debug_osc_pins,
  output logic                           debug_enable,
  output logic                           debug_erase_on_fail
);

  // ----------------------------------------------------------------
  // Loader state
  // ----------------------------------------------------------------
  obcl_pkg::obcl_ld_state_t state_q, state_d;
  obcl_pkg::obcl_cfg_t      cfg_q;
  logic [2:0]               slot_q;
  logic [15:0]              base_q;
  logic                     req_q, done_q, hold_q, swap_q;
  logic [15:0]              addr_q;

  wire logic take_byte = (state_q == obcl_pkg::OBCL_LD_WAIT) && flash_ack;
  wire logic last_byte = (slot_q == obcl_pkg::OBCL_LAST_SLOT);

  // Loader sequence: one request per byte, dropped between bytes
  always_comb begin
    state_d = state_q;
    case (state_q)
      obcl_pkg::OBCL_LD_START: state_d = obcl_pkg::OBCL_LD_READ;
      obcl_pkg::OBCL_LD_READ:  state_d = obcl_pkg::OBCL_LD_WAIT;
      obcl_pkg::OBCL_LD_WAIT: begin
        if (flash_ack) begin
          state_d = last_byte ? obcl_pkg::OBCL_LD_DONE : obcl_pkg::OBCL_LD_READ;
        end
      end
      default: state_d = obcl_pkg::OBCL_LD_DONE;
    endcase
  end

  // Sequencer registers; the base is caught once, after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= obcl_pkg::OBCL_LD_START;
      slot_q  <= '0;
      base_q  <= obcl_pkg::OBCL_PRI_BASE;
      swap_q  <= 1'b0;
      req_q   <= 1'b0;
      addr_q  <= '0;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == obcl_pkg::OBCL_LD_START) begin
        base_q <= boot_swap ? obcl_pkg::OBCL_ALT_BASE : obcl_pkg::OBCL_PRI_BASE;
        swap_q <= boot_swap;
      end
      if (state_q == obcl_pkg::OBCL_LD_READ) begin
        req_q  <= 1'b1;
        addr_q <= base_q + {13'h0, slot_q};
      end else if (take_byte) begin
        req_q  <= 1'b0;
        slot_q <= last_byte ? slot_q : slot_q + 3'h1;
      end
      done_q <= done_q || (take_byte && last_byte);
    end
  end

  // Field capture, one byte at a time; nothing changes once loaded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= obcl_pkg::OBCL_CFG_RST;
    end else if (take_byte && !done_q) begin
      case (slot_q)
        3'h0: begin
          cfg_q.window    <= flash_rdata[obcl_pkg::OBCL_WIN_LSB +: 2];
          cfg_q.autostart <= flash_rdata[obcl_pkg::OBCL_WDT_AUTOSTART_BIT];
          cfg_q.ovf_sel   <= flash_rdata[obcl_pkg::OBCL_OVF_LSB +: 3];
          cfg_q.osc_lock  <= flash_rdata[obcl_pkg::OBCL_LOCK_BIT];
        end
        3'h1: cfg_q.lvd_start    <= flash_rdata[obcl_pkg::OBCL_LVD_BIT];
        3'h2: cfg_q.hso_4mhz     <= flash_rdata[obcl_pkg::OBCL_HSO_BIT];
        3'h3: cfg_q.dbg_osc_pins <= flash_rdata[obcl_pkg::OBCL_DBGPIN_BIT];
        default: cfg_q.dbg_ctrl  <= flash_rdata[obcl_pkg::OBCL_DBG_LSB +: 2];
      endcase
    end
  end

  // Raw bytes kept for software readback; byte 0 also feeds a sanity flag
  logic [7:0] store_rd;
  logic       wdt_bad_q;
  logic [3:0] ap_slot;
  obcl_opt_store #(
    .DEPTH (obcl_pkg::OBCL_NUM_OPT),
    .WIDTH (8)
  ) u_store (
    .clk       (clk),
    .rst       (rst),
    .wr_en     (take_byte && !done_q),
    .wr_idx    (slot_q),
    .wr_data   (flash_rdata),
    .rd_idx    (ap_slot[2:0]),
    .rd_data_q (store_rd)
  );

  // ----------------------------------------------------------------
  // Supply level and reset hold
  // ----------------------------------------------------------------
  logic [1:0] hi_sync_q, lo_sync_q;

  // Two-stage synchronisers for the comparator outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_sync_q <= '0;
      lo_sync_q <= '0;
    end else begin
      hi_sync_q <= {hi_sync_q[0], supply_above_hi};
      lo_sync_q <= {lo_sync_q[0], supply_above_lo};
    end
  end

  // Before the byte is loaded the lower level applies, the safe default
  wire logic supply_ok = cfg_q.lvd_start ? hi_sync_q[1] : lo_sync_q[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= !done_q || !supply_ok;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog and oscillator clock gating
  // ----------------------------------------------------------------
  logic wdt_clk_q, osc_run_q, aux_clk_q, ctrl_aux_q;

  // Self-programming is deliberately absent from the gate terms
  wire logic wdt_gate = !cfg_q.osc_lock && (halt_mode || stop_mode);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_clk_q <= 1'b0;
      osc_run_q <= 1'b1;
      aux_clk_q <= 1'b0;
    end else begin
      wdt_clk_q <= done_q && cfg_q.autostart && !wdt_gate;
      osc_run_q <= cfg_q.osc_lock || !lowspeed_osc_stop_req;
      aux_clk_q <= ctrl_aux_q && (cfg_q.osc_lock || !lowspeed_osc_stop_req);
    end
  end

  // ----------------------------------------------------------------
  // Flash rewrite and read checks
  // ----------------------------------------------------------------
  logic grant_q, refuse_q, lp_dirty_q, fr_block_q;

  wire logic lvd_denied  = fw_req.lvd_byte && (!ext_programmer || self_prog || boot_swap);
  wire logic area_denied = !fw_req.data_area && rmc_low_power;
  wire logic fw_ok       = fw_req.valid && !lvd_denied && !area_denied;

  // Low-power writes leave a mark that blocks normal-mode reads until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grant_q    <= 1'b0;
      refuse_q   <= 1'b0;
      lp_dirty_q <= 1'b0;
      fr_block_q <= 1'b0;
    end else begin
      grant_q    <= fw_ok;
      refuse_q   <= fw_req.valid && !fw_ok;
      lp_dirty_q <= lp_dirty_q || (fw_ok && rmc_low_power);
      fr_block_q <= fr_req && lp_dirty_q && !rmc_low_power;
    end
  end

  // Sanity flag for the forbidden watchdog combination or bit 7 set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdt_bad_q <= 1'b0;
    end else if (take_byte && !done_q && (slot_q == 3'h0)) begin
      wdt_bad_q <= flash_rdata[obcl_pkg::OBCL_RSVD_BIT] || (flash_rdata[6:1] == 6'h00);
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic        dp_rd_q, dp_wr_q, rdy_q;
  logic [31:0] dp_addr_q, rdata_q;

  wire logic ap_valid = hsel && htrans[1] && hready;
  assign ap_slot = obcl_pkg::obcl_opt_slot(haddr);
  wire logic [3:0] dp_slot = obcl_pkg::obcl_opt_slot(dp_addr_q);
  wire logic hit_st = (dp_addr_q == obcl_pkg::obcl_reg_addr(obcl_pkg::OBCL_IDX_STATUS));
  wire logic hit_ct = (dp_addr_q == obcl_pkg::obcl_reg_addr(obcl_pkg::OBCL_IDX_CTRL));
  wire logic [obcl_pkg::OBCL_ST_WIDTH-1:0] status = {lp_dirty_q, wdt_bad_q,
                                                     cfg_q.dbg_ctrl == obcl_pkg::OBCL_DBG_FORBID,
                                                     swap_q, done_q};
  wire logic [31:0] rd_mux = dp_slot[3] ? {24'h0, store_rd} :
                             hit_st     ? {27'h0, status}   :
                             hit_ct     ? {31'h0, ctrl_aux_q} : 32'h0;

  // Transfer tracking; reads take one wait state for the store
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dp_rd_q   <= 1'b0;
      dp_wr_q   <= 1'b0;
      dp_addr_q <= '0;
      rdy_q     <= 1'b1;
    end else begin
      if (rdy_q) begin
        dp_rd_q   <= ap_valid && !hwrite;
        dp_wr_q   <= ap_valid && hwrite;
        dp_addr_q <= haddr;
      end
      rdy_q <= !(ap_valid && !hwrite && rdy_q);
    end
  end

  // Read data and the control register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q    <= '0;
      ctrl_aux_q <= obcl_pkg::OBCL_CTRL_RST;
    end else begin
      if (dp_rd_q && !rdy_q) begin
        rdata_q <= rd_mux;
      end
      if (dp_wr_q && rdy_q && hit_ct) begin
        ctrl_aux_q <= hwdata[obcl_pkg::OBCL_CTRL_AUXLS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout             = rdy_q;
  assign hresp                 = 1'b0;          // Always OKAY
  assign hrdata                = rdata_q;
  assign flash_req             = req_q;
  assign flash_addr            = addr_q;
  assign fw_grant              = grant_q;
  assign fw_refuse             = refuse_q;
  assign fr_block              = fr_block_q;
  assign cpu_reset_hold        = hold_q;
  assign cfg_done              = done_q;
  assign wdt_window_sel        = cfg_q.window;
  assign wdt_autostart         = cfg_q.autostart;
  assign wdt_access_det_en     = cfg_q.autostart;
  assign wdt_clk_en            = wdt_clk_q;
  assign lowspeed_osc_lock     = cfg_q.osc_lock;
  assign lowspeed_osc_run      = osc_run_q;
  assign aux_8bit_timer_clk_en = aux_clk_q;
  assign lvd_default_start     = cfg_q.lvd_start;
  assign hs_osc_4mhz           = cfg_q.hso_4mhz;
  assign debug_osc_pins        = cfg_q.dbg_osc_pins;
  assign debug_enable          = cfg_q.dbg_ctrl[1];

  // Exponent table kept in the package, looked up into a register here
  // The erase decode is registered too, so no output comes from a gate
  logic [4:0] exp_q;
  logic       erase_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exp_q   <= obcl_pkg::obcl_ovf_exp(3'h0);
      erase_q <= 1'b0;
    end else begin
      exp_q   <= obcl_pkg::obcl_ovf_exp(cfg_q.ovf_sel);
      erase_q <= (cfg_q.dbg_ctrl == obcl_pkg::OBCL_DBG_ERASE);
    end
  end
  assign wdt_overflow_exp    = exp_q;
  assign debug_erase_on_fail = erase_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_hold_until_load: assert property (@(posedge clk) disable iff (rst)
    !done_q |=> hold_q) else $error("reset hold released before load");
  a_base_select: assert property (@(posedge clk) disable iff (rst)
    (state_q == obcl_pkg::OBCL_LD_START) |=>
      (base_q == ($past(boot_swap) ? obcl_pkg::OBCL_ALT_BASE : obcl_pkg::OBCL_PRI_BASE)))
    else $error("wrong option byte base");
  a_cfg_frozen: assert property (@(posedge clk) disable iff (rst)
    done_q ##1 done_q |-> $stable(cfg_q)) else $error("configuration changed after load");
  a_lvd_level: assert property (@(posedge clk) disable iff (rst)
    (done_q && cfg_q.lvd_start && !hi_sync_q[1]) |=> hold_q) else $error("high level ignored");
  a_lvd_guard: assert property (@(posedge clk) disable iff (rst)
    (fw_req.valid && fw_req.lvd_byte && (self_prog || boot_swap)) |=> (refuse_q && !grant_q))
    else $error("start option write accepted");
  a_lp_prog_area: assert property (@(posedge clk) disable iff (rst)
    (fw_req.valid && !fw_req.data_area && rmc_low_power) |=> refuse_q) else $error("program area rewrite in low power");
  a_lp_read_block: assert property (@(posedge clk) disable iff (rst)
    (fw_ok && rmc_low_power) ##1 (fr_req && !rmc_low_power) |=> fr_block_q) else $error("read not blocked");
  a_wdt_gate: assert property (@(posedge clk) disable iff (rst)
    (!cfg_q.osc_lock && stop_mode) |=> !wdt_clk_q) else $error("watchdog clock not gated");
  a_wdt_selfprog: assert property (@(posedge clk) disable iff (rst)
    (done_q && cfg_q.autostart && self_prog && !halt_mode && !stop_mode) |=> wdt_clk_q)
    else $error("watchdog stopped in self-programming");
  a_aux_clock: assert property (@(posedge clk) disable iff (rst)
    (ctrl_aux_q && cfg_q.osc_lock && halt_mode) |=> aux_clk_q) else $error("timer clock lost in halt");
  a_read_wait: assert property (@(posedge clk) disable iff (rst)
    (ap_valid && !hwrite && rdy_q) |=> !rdy_q ##1 rdy_q) else $error("read wait state wrong");

  c_load_done: cover property (@(posedge clk) disable iff (rst) $rose(done_q));
  c_swap_load: cover property (@(posedge clk) disable iff (rst) swap_q && $rose(done_q));
  c_refused:   cover property (@(posedge clk) disable iff (rst) refuse_q);
  c_bus_read:  cover property (@(posedge clk) disable iff (rst) dp_rd_q && dp_slot[3] && rdy_q);

endmodule

// ==== hdl/obcl_opt_store.sv ====
// Small store for the raw option bytes with registered read data
`timescale 1ns/100ps
module obcl_opt_store #(
  parameter int unsigned DEPTH = 5,
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [2:0]       wr_idx,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [2:0]       rd_idx,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port; slots beyond the depth are ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= obcl_pkg::OBCL_OPT_RST;
      end
    end else if (wr_en && (32'(wr_idx) < DEPTH)) begin
      mem_q[wr_idx] <= wr_data;
    end
  end

  // Registered read; out-of-range slots read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= '0;
    end else if (32'(rd_idx) < DEPTH) begin
      rd_data_q <= mem_q[rd_idx];
    end else begin
      rd_data_q <= '0;
    end
  end

endmodule

// ==== hdl/obcl_pkg.sv ====
// Constants, types and helper functions for the option byte configuration loader
package obcl_pkg;

  // ----------------------------------------------------------------
  // Option byte area
  // ----------------------------------------------------------------
  localparam int unsigned OBCL_NUM_OPT   = 5;
  localparam logic [15:0] OBCL_PRI_BASE  = 16'h0080;  // Primary option byte area
  localparam logic [15:0] OBCL_ALT_BASE  = 16'h1080;  // Area used under boot swap
  localparam logic [2:0]  OBCL_LAST_SLOT = 3'h4;
  localparam logic [7:0]  OBCL_OPT_RST   = 8'h00;     // Byte value before loading

  // Byte 0: watchdog and low-speed oscillator
  localparam int unsigned OBCL_WIN_LSB   = 5;
  localparam int unsigned OBCL_WDT_AUTOSTART_BIT = 4;
  localparam int unsigned OBCL_OVF_LSB   = 1;
  localparam int unsigned OBCL_LOCK_BIT  = 0;
  localparam int unsigned OBCL_RSVD_BIT  = 7;
  // Bytes 1 to 4
  localparam int unsigned OBCL_LVD_BIT    = 0;
  localparam int unsigned OBCL_HSO_BIT    = 0;        // 1 selects 4 MHz, 0 selects 8 MHz
  localparam int unsigned OBCL_DBGPIN_BIT = 1;        // 1 selects the oscillator pins
  localparam int unsigned OBCL_DBG_LSB    = 0;

  localparam logic [1:0] OBCL_DBG_OFF       = 2'h0;
  localparam logic [1:0] OBCL_DBG_FORBID    = 2'h1;
  localparam logic [1:0] OBCL_DBG_ERASE     = 2'h3;

  // ----------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is 4x
  // ----------------------------------------------------------------
  localparam logic [31:0] OBCL_IDX_OPT0   = 32'h0000_0080;
  localparam logic [31:0] OBCL_IDX_STATUS = 32'h0000_0090;
  localparam logic [31:0] OBCL_IDX_CTRL   = 32'h0000_0091;

  localparam int unsigned OBCL_ST_DONE     = 0;
  localparam int unsigned OBCL_ST_SWAP     = 1;
  localparam int unsigned OBCL_ST_DBGBAD   = 2;
  localparam int unsigned OBCL_ST_WDTBAD   = 3;
  localparam int unsigned OBCL_ST_LPDIRTY  = 4;
  localparam int unsigned OBCL_ST_WIDTH    = 5;
  localparam int unsigned OBCL_CTRL_AUXLS  = 0;
  localparam logic [0:0]  OBCL_CTRL_RST    = 1'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OBCL_LD_START, OBCL_LD_READ, OBCL_LD_WAIT, OBCL_LD_DONE} obcl_ld_state_t;

  typedef struct packed {
    logic [1:0] window;
    logic       autostart;
    logic [2:0] ovf_sel;
    logic       osc_lock;
    logic       lvd_start;
    logic       hso_4mhz;
    logic       dbg_osc_pins;
    logic [1:0] dbg_ctrl;
  } obcl_cfg_t;

  localparam obcl_cfg_t OBCL_CFG_RST = '0;

  typedef struct packed {
    logic valid;
    logic data_area;
    logic lvd_byte;
  } obcl_flash_req_t;

  // Watchdog overflow exponent in low-speed clock periods
  function automatic logic [4:0] obcl_ovf_exp(input logic [2:0] sel);
    case (sel)
      3'h0:    obcl_ovf_exp = 5'h07;
      3'h1:    obcl_ovf_exp = 5'h08;
      3'h2:    obcl_ovf_exp = 5'h09;
      3'h3:    obcl_ovf_exp = 5'h0A;
      3'h4:    obcl_ovf_exp = 5'h0C;
      3'h5:    obcl_ovf_exp = 5'h0E;
      3'h6:    obcl_ovf_exp = 5'h0F;
      default: obcl_ovf_exp = 5'h11;
    endcase
  endfunction

  // Byte address of a register index
  function automatic logic [31:0] obcl_reg_addr(input logic [31:0] idx);
    obcl_reg_addr = {idx[29:0], 2'b00};
  endfunction

  // Option byte slot hit, slot number in the low three bits
  function automatic logic [3:0] obcl_opt_slot(input logic [31:0] addr);
    logic [29:0] off;
    off = addr[31:2] - OBCL_IDX_OPT0[29:0];
    obcl_opt_slot = {(off <= 30'(OBCL_LAST_SLOT)) && (addr[1:0] == 2'b00), off[2:0]};
  endfunction

endpackage

// ==== tb/obcl_flash_model.sv ====
// Behavioural flash option byte area answering the loader's byte reads
`timescale 1ns/100ps
module obcl_flash_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        flash_req,
  input  wire logic [15:0] flash_addr,
  input  wire logic [39:0] pri_img,
  input  wire logic [39:0] alt_img,
  input  wire logic [3:0]  delay,
  output logic             flash_ack,
  output logic      [7:0]  flash_rdata
);
  logic [3:0]  cnt_q;
  logic        served_q;
  // Alternate image selected by address; bench gives it bytes that differ from the primary image
  wire  [39:0] img = flash_addr[12] ? alt_img : pri_img;
  // One ack per request; data toggles when not valid so a stale byte never passes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_ack   <= 1'b0;
      flash_rdata <= 8'hA5;
      cnt_q       <= 4'h0;
      served_q    <= 1'b0;
    end else if (flash_req && !flash_ack && !served_q && cnt_q == delay) begin
      flash_ack   <= 1'b1;
      flash_rdata <= img[8*flash_addr[2:0] +: 8];
      served_q    <= 1'b1;
    end else begin
      flash_ack   <= 1'b0;
      flash_rdata <= ~flash_rdata;
      cnt_q       <= (flash_req && !served_q) ? cnt_q + 4'h1 : 4'h0;
      served_q    <= served_q && flash_req;
    end
  end
endmodule

// ==== tb/obcl_loader_test.sv ====
// Self-checking bench for the option byte loader
`timescale 1ns/100ps
module obcl_loader_test;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, flash_req, flash_ack, fr_req = 0;
  logic boot_swap = 0, self_prog = 0, ext_programmer = 0, rmc_low_power = 0, halt_mode = 0, stop_mode = 0;
  logic lowspeed_osc_stop_req = 0, supply_above_hi = 0, supply_above_lo = 1, fw_grant, fw_refuse, fr_block;
  logic cpu_reset_hold, cfg_done, wdt_autostart, wdt_access_det_en, wdt_clk_en, lowspeed_osc_lock;
  logic lowspeed_osc_run, aux_8bit_timer_clk_en, lvd_default_start, hs_osc_4mhz, debug_osc_pins;
  logic debug_enable, debug_erase_on_fail;
  logic [1:0] htrans = 0, wdt_window_sel;
  logic [2:0] hsize = 3'h2;
  logic [4:0] wdt_overflow_exp;
  logic [7:0] flash_rdata;
  logic [15:0] flash_addr;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [39:0] pri = 40'h02_1E_01_00_30, alt = 40'h03_00_00_01_5F;
  logic [3:0] dly = 4'h0;
  obcl_pkg::obcl_flash_req_t fw_req = '0;
  int miscompares = 0, total_checks = 0;
  assign hready = hreadyout;
  always #5 clk = ~clk;
  obcl_loader dut_u (.*);
  obcl_flash_model flash_u (.clk(clk), .rst(rst), .flash_req(flash_req), .flash_addr(flash_addr),
    .pri_img(pri), .alt_img(alt), .delay(dly), .flash_ack(flash_ack), .flash_rdata(flash_rdata));
  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address phase held until hready, then data phase held until hready again
  // Select stays high between calls; an IDLE htrans alone ends the transfer
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; haddr <= a; hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic boot();
    rst <= 1;
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 300 && cfg_done !== 1'b1; i++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  // One rewrite or read check; result pulse lands one cycle later
  task automatic req(logic fw, logic [2:0] v, logic [2:0] e);
    fw_req <= fw ? v : 3'h0; fr_req <= !fw;
    @(posedge clk);
    fw_req <= 3'h0; fr_req <= 0;
    #1 chk("grant_refuse_block", {fw_grant, fw_refuse, fr_block}, e);
    @(posedge clk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000 miscompares++;
    stop_test();
  end
  initial begin
    // Primary area, low release level, oscillator may stop
    boot();
    chk("cfg", {wdt_window_sel, wdt_autostart, wdt_access_det_en, lowspeed_osc_lock}, 5'h0E);
    chk("ovf", wdt_overflow_exp, 5'h07);
    chk("misc", {lvd_default_start, hs_osc_4mhz, debug_osc_pins, debug_enable, debug_erase_on_fail}, 5'h0E);
    chk("hold", {cfg_done, cpu_reset_hold}, 2'h2);
    for (int i = 0; i < 5; i++) begin
      bus(0, 32'h200 + 4 * i, 0);
      chk("opt", rd, {24'h0, pri[8*i +: 8]});
    end
    chk("hresp", hresp, 1'b0);
    pri <= 40'hFF_FF_FF_FF_FF;
    bus(0, 32'h240, 0);
    chk("status", rd, 32'h1);
    bus(0, 32'h300, 0);
    chk("unmapped", rd, 32'h0);
    bus(1, 32'h244, 32'h1);
    bus(0, 32'h244, 0);
    chk("ctrl", rd, 32'h1);
    halt_mode <= 1;
    repeat (3) @(posedge clk);
    chk("halt_clk", {wdt_clk_en, aux_8bit_timer_clk_en}, 2'h1);
    halt_mode <= 0; stop_mode <= 1;
    repeat (3) @(posedge clk);
    chk("stop_clk", {wdt_clk_en, aux_8bit_timer_clk_en}, 2'h1);
    stop_mode <= 0; self_prog <= 1; lowspeed_osc_stop_req <= 1;
    repeat (3) @(posedge clk);
    chk("selfprog_clk", {wdt_clk_en, lowspeed_osc_run}, 2'h2);
    self_prog <= 0; ext_programmer <= 1;
    req(1, 3'h5, 3'h4);
    $display("test primary done");
    // Swapped area with slow flash, high release level, locked oscillator
    pri <= 40'h02_1E_01_00_30; dly <= 4'h7; boot_swap <= 1; halt_mode <= 1;
    boot();
    chk("cfg2", {wdt_window_sel, wdt_autostart, wdt_access_det_en, lowspeed_osc_lock}, 5'h17);
    chk("ovf2", wdt_overflow_exp, 5'h11);
    chk("misc2", {lvd_default_start, hs_osc_4mhz, debug_osc_pins, debug_enable, debug_erase_on_fail}, 5'h13);
    chk("run2", {wdt_clk_en, lowspeed_osc_run, cpu_reset_hold}, 3'h7);
    bus(1, 32'h244, 32'h1);
    repeat (2) @(posedge clk);
    chk("aux2", aux_8bit_timer_clk_en, 1'b1);
    supply_above_hi <= 1;
    repeat (6) @(posedge clk);
    chk("hold2", cpu_reset_hold, 1'b0);
    req(1, 3'h5, 3'h2);
    rmc_low_power <= 1;  // No self-programming around the switch
    req(1, 3'h4, 3'h2);
    req(1, 3'h6, 3'h4);
    rmc_low_power <= 0;
    req(0, 3'h0, 3'h1);
    bus(0, 32'h240, 0);
    chk("status2", rd, 32'h13);
    $display("test swap done");
    stop_test();
  end
endmodule
